// >>> verilog/spi_eeprom_command_protect.v
`timescale 1ns/1ps
`include "eeprom_front_regs.vh"

// Behaviour
// - Sample serial input on rising clock edge.
// - Change serial output on falling edge.
// - Output released while deselected; write continues.
// - First eight bits form opcode; unknowns ignored.
// - Decode set, clear latch, read status.
// - Decode write status, read, write memory.
// - Busy bit set during write, host-immutable.
// - Latch set and cleared by commands.
// - Guard bits written only by status write.
// - Guard code selects protected upper region.
// - Pin guard blocks status writes when active.
// - Latch clear rejects every write.
// - Page select routes access to id page.
// - Page select clears after read or write.
// - Page lock makes id page read-only.
// - Setting select and lock together changes neither.
// - Status layout fixed, bit five zero.
// - Internal write ends within write time.
// - Status write touches only bits 2,3,4,6,7.
// - During write only read status accepted.
// - Write completion clears the latch.
module spi_eeprom_command_protect #(
  parameter WRITE_CYCLES = `WRITE_CYCLES
) (
  // Clock and reset.
  input wire ref_clk,
  input wire rst,
  // Serial link pins from the host.
  input wire chip_sel_n,
  input wire serial_clk,
  input wire serial_in,
  input wire pause_n,
  input wire protect_n,
  // Serial output as a three-state pin.
  output reg serial_out,
  output wire serial_out_en,
  // Memory write port, fed through a two-entry buffer.
  output wire mem_wr_valid,
  input wire mem_wr_ready,
  output wire [12:0] mem_wr_addr,
  output wire [7:0] mem_wr_data,
  output wire mem_wr_id_page,
  // Memory read port, combinational lookup by address.
  output wire [12:0] mem_rd_addr,
  output wire mem_rd_id_page,
  input wire [7:0] mem_rd_data,
  // Status view.
  output wire [7:0] status_control,
  output wire internal_write_busy
);

  // States of the command sequencer, one-hot.
  localparam S_OPCODE = 6'b000001;
  localparam S_ADDR = 6'b000010;
  localparam S_WDATA = 6'b000100;
  localparam S_RDATA = 6'b001000;
  localparam S_STATUS = 6'b010000;
  localparam S_IGNORE = 6'b100000;

  // Two-flop synchronisers for every pin.
  reg [4:0] sync_a;
  reg [4:0] sync_b;
  reg [4:0] sync_c;
  always @(posedge ref_clk) begin
    sync_a <= {protect_n, pause_n, serial_in, serial_clk, chip_sel_n};
    sync_b <= sync_a;
    sync_c <= sync_b;
  end
  wire cs_n = sync_b[0];
  wire sck = sync_b[1];
  wire sdi = sync_b[2];
  wire hold_n = sync_b[3];
  wire wp_n = sync_b[4];
  wire sck_rise = sck & ~sync_c[1] & ~cs_n & hold_n;
  wire sck_fall = ~sck & sync_c[1] & ~cs_n & hold_n;
  wire cs_rise = cs_n & ~sync_c[0];

  // Status storage.
  reg write_latch;
  reg busy;
  reg id_page_select;
  reg id_page_lock;
  reg block_guard_lo;
  reg block_guard_hi;
  reg pin_guard_enable;
  assign status_control = {pin_guard_enable, id_page_select, 1'b0,
    id_page_lock, block_guard_hi, block_guard_lo, write_latch,
    busy};
  assign internal_write_busy = busy;

  // Protection decisions.
  wire hw_guard = ~wp_n & pin_guard_enable;
  wire status_writable = write_latch & ~hw_guard;

  // Shift and frame state.
  reg [5:0] state;
  reg [2:0] bit_cnt;
  reg [7:0] shift_in;
  reg [7:0] opcode;
  reg [15:0] addr;
  reg [4:0] addr_bytes;
  reg [7:0] shift_out;
  reg [7:0] new_status;
  reg status_pending;
  reg mem_written;
  reg frame_accessed;
  wire [7:0] next_byte = {shift_in[6:0], sdi};
  wire byte_done = sck_rise & (bit_cnt == 3'd7);

  // Address is protected per the guard code.
  function guarded;
    input [12:0] a;
    input [1:0] code;
    begin
      case (code)
        2'b01: guarded = (a >= `GUARD_QUARTER);
        2'b10: guarded = (a >= `GUARD_HALF);
        2'b11: guarded = 1'b1;
        default: guarded = 1'b0;
      endcase
    end
  endfunction

  wire [1:0] guard_code = {block_guard_hi, block_guard_lo};
  wire [12:0] cur_addr = addr[12:0];
  wire byte_writable = write_latch & (id_page_select ?
    (~id_page_lock & ~guarded({8'h00, cur_addr[4:0]}, guard_code)) :
    ~guarded(cur_addr, guard_code));

  // Two-entry write buffer.
  reg [21:0] buf_data [0:1];
  reg [1:0] buf_cnt;
  reg buf_rd;
  reg buf_wr;
  wire buf_in_ready = (buf_cnt != 2'd2);
  wire buf_push = byte_done & (state == S_WDATA) & byte_writable &
    buf_in_ready;
  wire buf_pop = mem_wr_valid & mem_wr_ready;
  assign mem_wr_valid = (buf_cnt != 2'd0);
  assign mem_wr_addr = buf_data[buf_rd][20:8];
  assign mem_wr_data = buf_data[buf_rd][7:0];
  assign mem_wr_id_page = buf_data[buf_rd][21];
  assign mem_rd_addr = id_page_select ? {8'h00, cur_addr[4:0]} : cur_addr;
  assign mem_rd_id_page = id_page_select;

  // Buffer pointers and storage.
  always @(posedge ref_clk) begin
    if (rst) begin
      buf_cnt <= 2'd0;
      buf_rd <= 1'b0;
      buf_wr <= 1'b0;
    end else begin
      if (buf_push) begin
        buf_data[buf_wr] <= {id_page_select, cur_addr, next_byte};
        buf_wr <= ~buf_wr;
      end
      if (buf_pop)
        buf_rd <= ~buf_rd;
      if (buf_push & ~buf_pop)
        buf_cnt <= buf_cnt + 2'd1;
      else if (buf_pop & ~buf_push)
        buf_cnt <= buf_cnt - 2'd1;
    end
  end

  // Internal write timer.
  reg [31:0] wr_timer;

  // Command sequencer, status update and write timing.
  always @(posedge ref_clk) begin
    if (rst) begin
      state <= S_OPCODE;
      bit_cnt <= 3'd0;
      shift_in <= 8'h00;
      opcode <= 8'h00;
      addr <= 16'h0000;
      addr_bytes <= 5'd0;
      write_latch <= 1'b0;
      busy <= 1'b0;
      id_page_select <= 1'b0;
      status_pending <= 1'b0;
      new_status <= 8'h00;
      mem_written <= 1'b0;
      frame_accessed <= 1'b0;
      wr_timer <= 32'd0;
      shift_out <= 8'h00;
    end else begin
      // Running write continues regardless of chip select.
      if (busy) begin
        if (wr_timer >= WRITE_CYCLES - 1) begin
          busy <= 1'b0;
          write_latch <= 1'b0;
          wr_timer <= 32'd0;
        end else begin
          wr_timer <= wr_timer + 32'd1;
        end
      end
      if (cs_n) begin
        state <= S_OPCODE;
        bit_cnt <= 3'd0;
        addr_bytes <= 5'd0;
      end
      if (cs_rise) begin
        // Frame end launches any valid write.
        if (status_pending) begin
          pin_guard_enable <= new_status[`ST_PIN_GUARD];
          block_guard_hi <= new_status[`ST_GUARD_HI];
          block_guard_lo <= new_status[`ST_GUARD_LO];
          if (~(new_status[`ST_PAGE_SELECT] &
              new_status[`ST_PAGE_LOCK])) begin
            id_page_select <= new_status[`ST_PAGE_SELECT];
            id_page_lock <= id_page_lock | new_status[`ST_PAGE_LOCK];
          end
          busy <= 1'b1;
        end
        if (mem_written)
          busy <= 1'b1;
        if (frame_accessed)
          id_page_select <= 1'b0;
        status_pending <= 1'b0;
        mem_written <= 1'b0;
        frame_accessed <= 1'b0;
      end
      if (sck_rise) begin
        bit_cnt <= bit_cnt + 3'd1;
        shift_in <= next_byte;
      end
      if (byte_done) begin
        case (state)
          S_OPCODE: begin
            opcode <= next_byte;
            if (next_byte == `OP_READ_STATUS) begin
              state <= S_STATUS;
              shift_out <= status_control;
            end else if (busy) begin
              state <= S_IGNORE;
            end else if (next_byte == `OP_SET_WRITE_LATCH) begin
              write_latch <= 1'b1;
              state <= S_IGNORE;
            end else if (next_byte == `OP_CLEAR_WRITE_LATCH) begin
              write_latch <= 1'b0;
              state <= S_IGNORE;
            end else if (next_byte == `OP_WRITE_STATUS ||
                next_byte == `OP_READ_MEM ||
                next_byte == `OP_WRITE_MEM) begin
              state <= S_ADDR;
            end else begin
              state <= S_IGNORE;
            end
          end
          S_ADDR: begin
            if (opcode == `OP_WRITE_STATUS) begin
              if (status_writable) begin
                new_status <= next_byte;
                status_pending <= 1'b1;
              end
              state <= S_IGNORE;
            end else begin
              addr <= {addr[7:0], next_byte};
              addr_bytes <= addr_bytes + 5'd1;
              if (addr_bytes == 5'd1) begin
                if (opcode == `OP_READ_MEM) begin
                  state <= S_RDATA;
                  frame_accessed <= 1'b1;
                end else begin
                  state <= S_WDATA;
                end
              end
            end
          end
          S_WDATA: begin
            // Page roll-over keeps the upper address bits.
            addr[4:0] <= addr[4:0] + 5'd1;
            if (buf_push) begin
              mem_written <= 1'b1;
              frame_accessed <= 1'b1;
            end
          end
          S_RDATA: begin
            if (id_page_select)
              addr[4:0] <= addr[4:0] + 5'd1;
            else
              addr <= addr + 16'd1;
          end
          S_STATUS: begin
            shift_out <= status_control;
          end
          default: begin
            state <= S_IGNORE;
          end
        endcase
      end
      // Read data is taken at the first falling edge of each byte, once
      // the address has settled.
      if (state == S_RDATA && sck_fall && bit_cnt == 3'd0)
        shift_out <= mem_rd_data;
    end
  end

  // Non-volatile bits hold their value over reset.
  initial begin
    {pin_guard_enable, id_page_lock, block_guard_hi, block_guard_lo} =
      `NV_RESET;
  end

  // Output shifts on falling edges, MSB first.
  always @(posedge ref_clk) begin
    if (rst)
      serial_out <= 1'b0;
    else if (sck_fall) begin
      // A read byte's first bit comes straight from the store.
      if (state == S_RDATA && bit_cnt == 3'd0)
        serial_out <= mem_rd_data[7];
      else
        serial_out <= shift_out[3'd7 - bit_cnt];
    end
  end

  // Driven only while selected, not paused, and sending.
  assign serial_out_en = ~cs_n & hold_n &
    (state == S_RDATA || state == S_STATUS);

endmodule

// >>> verilog/eeprom_front_regs.vh
`ifndef EEPROM_FRONT_REGS_VH
`define EEPROM_FRONT_REGS_VH
// Opcodes.
`define OP_SET_WRITE_LATCH 8'h06
`define OP_CLEAR_WRITE_LATCH 8'h04
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_READ_MEM 8'h03
`define OP_WRITE_MEM 8'h02
// Status and control bit positions.
`define ST_BUSY 0
`define ST_WRITE_LATCH 1
`define ST_GUARD_LO 2
`define ST_GUARD_HI 3
`define ST_PAGE_LOCK 4
`define ST_ZERO 5
`define ST_PAGE_SELECT 6
`define ST_PIN_GUARD 7
// Bits that the status write may change.
`define ST_WRITE_MASK 8'hDC
// Power-up value of the non-volatile bits.
`define NV_RESET 4'h0
// Array size and protected block starts.
`define ADDR_BITS 13
`define GUARD_QUARTER 13'h1800
`define GUARD_HALF 13'h1000
`define ID_PAGE_BYTES 32
// Timing: internal write time in microseconds and clock rate in MHz.
`define INTERNAL_WRITE_TIME_US 4000
`define REF_CLK_MHZ 250
`define WRITE_CYCLES (`INTERNAL_WRITE_TIME_US * `REF_CLK_MHZ)
`endif

// >>> dv/spi_eeprom_monitor.sv
`timescale 1ns/1ps
module spi_eeprom_monitor #(
  parameter WRITE_CYCLES = 1000
) (
  // Clock and reset.
  input wire ref_clk,
  input wire rst,
  // Watched ports.
  input wire chip_sel_n,
  input wire serial_clk,
  input wire serial_out,
  input wire serial_out_en,
  input wire mem_wr_valid,
  input wire mem_wr_ready,
  input wire [12:0] mem_wr_addr,
  input wire [7:0] mem_wr_data,
  input wire [7:0] status_control,
  input wire internal_write_busy
);
  reg [31:0] busy_len;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Counts the cycles of the running internal write.
  always @(posedge ref_clk) begin
    if (rst || !internal_write_busy)
      busy_len <= 32'h0000_0000;
    else
      busy_len <= busy_len + 32'h0000_0001;
  end
  a_busy_len_bound: assert property (busy_len <= WRITE_CYCLES)
    else $error("Internal write ran too long.");
  a_out_released: assert property (chip_sel_n [*4] |-> !serial_out_en)
    else $error("Output driven while deselected.");
  a_out_on_fall: assert property (
    serial_out_en && $past(serial_out_en) && $changed(serial_out)
    |-> !serial_clk) else $error("Output moved while clock high.");
  a_zero_bit_five: assert property (status_control[5] == 1'b0)
    else $error("Status bit five set.");
  a_busy_in_status: assert property (
    status_control[0] == internal_write_busy)
    else $error("Busy bit differs from busy port.");
  a_busy_after_cs: assert property (
    $rose(internal_write_busy) |-> chip_sel_n)
    else $error("Write started inside a frame.");
  a_busy_end_latch: assert property (
    $fell(internal_write_busy) |-> !status_control[1])
    else $error("Latch still set after write.");
  a_busy_freezes_bits: assert property (
    internal_write_busy && $past(internal_write_busy)
    |-> $stable(status_control[7:1]))
    else $error("Status changed during write.");
  a_nv_in_idle: assert property (
    $changed(status_control & 8'h9c) |-> chip_sel_n)
    else $error("Stored bits changed inside a frame.");
  a_buf_hold_word: assert property (
    mem_wr_valid && !mem_wr_ready |=> mem_wr_valid
    && $stable(mem_wr_addr) && $stable(mem_wr_data))
    else $error("Stalled word was not held.");
endmodule
bind spi_eeprom_command_protect spi_eeprom_monitor #(
  .WRITE_CYCLES(WRITE_CYCLES)
) mon (
  .ref_clk(ref_clk), .rst(rst), .chip_sel_n(chip_sel_n),
  .serial_clk(serial_clk), .serial_out(serial_out),
  .serial_out_en(serial_out_en), .mem_wr_valid(mem_wr_valid),
  .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
  .mem_wr_data(mem_wr_data), .status_control(status_control),
  .internal_write_busy(internal_write_busy)
);

// >>> dv/eeprom_mem_model.sv
`timescale 1ns/1ps
module eeprom_mem_model (
  // Clock and stall control.
  input wire ref_clk,
  input wire stall,
  // Write side.
  input wire mem_wr_valid,
  output wire mem_wr_ready,
  input wire [12:0] mem_wr_addr,
  input wire [7:0] mem_wr_data,
  input wire mem_wr_id_page,
  // Read side.
  input wire [12:0] mem_rd_addr,
  input wire mem_rd_id_page,
  output wire [7:0] mem_rd_data
);
  reg [7:0] main_mem [0:8191];
  reg [7:0] id_mem [0:31];
  integer i;
  // Known fill so that unwritten places never read as unknown.
  initial begin
    for (i = 0; i < 8192; i = i + 1) main_mem[i] = 8'h5a;
    for (i = 0; i < 32; i = i + 1) id_mem[i] = 8'h5a;
  end
  // The stall input holds ready low.
  assign mem_wr_ready = !stall;
  // Stores each accepted word.
  always @(posedge ref_clk) begin
    if (mem_wr_valid && mem_wr_ready) begin
      if (mem_wr_id_page)
        id_mem[mem_wr_addr[4:0]] <= mem_wr_data;
      else
        main_mem[mem_wr_addr] <= mem_wr_data;
    end
  end
  // Reads answer at once from the addressed store.
  assign mem_rd_data = mem_rd_id_page ? id_mem[mem_rd_addr[4:0]] :
    main_mem[mem_rd_addr];
endmodule

// >>> dv/spi_eeprom_command_protect_test.sv
`timescale 1ns/1ps
module spi_eeprom_command_protect_test;
  localparam WC = 1000;
  // Power-up wait before the first read, scaled down like WC.
  localparam PUR = 100;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg chip_sel_n = 1'b1;
  reg serial_clk = 1'b0;
  reg serial_in = 1'b0;
  reg protect_n = 1'b1;
  reg stall = 1'b0;
  reg pause_n = 1'b1;
  reg cpol = 1'b0;
  integer hold_bit = -1;
  reg [31:0] rnd = 32'h0000_0031;
  reg [31:0] rx;
  reg [21:0] exp_wr [$];
  reg [21:0] want;
  reg [12:0] a;
  integer num_errors = 0;
  integer total_checks = 0;
  integer g;
  integer k;
  wire so, so_en, wr_v, wr_r, wr_id, rd_id, busy;
  wire [12:0] wr_a, rd_a;
  wire [7:0] wr_d, rd_d, st;
  spi_eeprom_command_protect #(.WRITE_CYCLES(WC)) dut (
    .ref_clk(ref_clk), .rst(rst), .chip_sel_n(chip_sel_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .pause_n(pause_n),
    .protect_n(protect_n), .serial_out(so), .serial_out_en(so_en),
    .mem_wr_valid(wr_v), .mem_wr_ready(wr_r), .mem_wr_addr(wr_a),
    .mem_wr_data(wr_d), .mem_wr_id_page(wr_id), .mem_rd_addr(rd_a),
    .mem_rd_id_page(rd_id), .mem_rd_data(rd_d), .status_control(st),
    .internal_write_busy(busy));
  eeprom_mem_model mem (
    .ref_clk(ref_clk), .stall(stall), .mem_wr_valid(wr_v),
    .mem_wr_ready(wr_r), .mem_wr_addr(wr_a), .mem_wr_data(wr_d),
    .mem_wr_id_page(wr_id), .mem_rd_addr(rd_a), .mem_rd_id_page(rd_id),
    .mem_rd_data(rd_d));
  // Clock, random source and memory stall.
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    rnd <= xs(rnd);
    stall <= rnd[1];
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One framed transfer of n bytes, clock at cpol at both frame edges.
  task frame(input [31:0] tx, input integer n);
    integer i;
    begin
      rx = 32'h0000_0000;
      chip_sel_n <= 1'b0;
      tick(6);
      for (i = 31; i > 31 - 8 * n; i = i - 1) begin
        serial_clk <= 1'b0;
        serial_in <= tx[i];
        tick(6);
        if (i == hold_bit) begin
          // Pause with the clock low; the pulse inside must be ignored.
          pause_n <= 1'b0;
          tick(6);
          serial_clk <= 1'b1;
          tick(6);
          serial_clk <= 1'b0;
          tick(6);
          pause_n <= 1'b1;
          tick(6);
        end
        // A released output reads as the inverse of its last value.
        rx[i] = so_en ? so : ~so;
        serial_clk <= 1'b1;
        tick(6);
      end
      serial_clk <= cpol;
      tick(6);
      chip_sel_n <= 1'b1;
      tick(12);
    end
  endtask
  task st_is(input [7:0] e);
    begin
      frame(32'h0500_0000, 2);
      check(rx[23:16], e);
      check(st, e);
    end
  endtask
  task wait_idle;
    integer i;
    begin
      for (i = 0; i < WC + 100 && busy !== 1'b0; i = i + 1) tick(1);
      check(busy, 1'b0);
    end
  endtask
  task wr_st(input [7:0] v);
    begin
      frame(32'h0600_0000, 1);
      frame({8'h01, v, 16'h0000}, 2);
      wait_idle;
    end
  endtask
  task wr_mem(input [12:0] wa, input [7:0] wd, input ok, input id);
    begin
      frame(32'h0600_0000, 1);
      if (ok) exp_wr.push_back({id, wa, wd});
      frame({8'h02, 3'b000, wa, wd}, 4);
    end
  endtask
  // Compares each accepted memory word with the oldest note.
  always @(posedge ref_clk) begin
    if (!rst && wr_v === 1'b1 && wr_r === 1'b1) begin
      want = exp_wr.size() ? exp_wr.pop_front() : ~{wr_id, wr_a, wr_d};
      check({wr_id, wr_a, wr_d}, want);
    end
  end
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // Watchdog against a hung run.
  initial begin
    #350000;
    num_errors = num_errors + 1;
    tally_and_finish;
  end
  // Main sequence.
  initial begin
    tick(12);
    rst <= 1'b0;
    tick(PUR);
    st_is(8'h00);
    frame({8'h02, 16'h0010, 8'h11}, 4);
    frame(32'h0600_0000, 1);
    st_is(8'h02);
    frame({1'b1, rnd[6:0], 24'h0}, 1);
    st_is(8'h02);
    frame(32'h0400_0000, 1);
    st_is(8'h00);
    a = {1'b0, rnd[19:8]};
    wr_mem(a, 8'hc3, 1'b1, 1'b0);
    st_is(8'h03);
    frame(32'h0400_0000, 1);
    st_is(8'h03);
    wait_idle;
    st_is(8'h00);
    frame({8'h03, 3'b000, a, 8'h00}, 4);
    check(rx[7:0], 8'hc3);
    for (g = 0; g < 4; g = g + 1) begin
      wr_st({4'h0, g[1:0], 2'b00});
      st_is({4'h0, g[1:0], 2'b00});
      for (k = 0; k < 3; k = k + 1) begin
        a = k == 0 ? 13'h0fff : k == 1 ? 13'h17ff : 13'h1800;
        wr_mem(a, rnd[7:0], !(g == 3 || (g == 2 && a >= 13'h1000) ||
          (g == 1 && a >= 13'h1800)), 1'b0);
        wait_idle;
      end
    end
    wr_st(8'h73);
    st_is(8'h00);
    wr_st(8'h84);
    // Mode (1,1): the clock idles high between frames.
    cpol = 1'b1;
    serial_clk <= 1'b1;
    tick(6);
    st_is(8'h84);
    cpol = 1'b0;
    serial_clk <= 1'b0;
    tick(6);
    protect_n <= 1'b0;
    wr_st(8'h00);
    hold_bit = 20;
    st_is(8'h86);
    hold_bit = -1;
    wr_mem(13'h1800, rnd[7:0], 1'b0, 1'b0);
    wr_mem(13'h0800, rnd[7:0], 1'b1, 1'b0);
    wait_idle;
    protect_n <= 1'b1;
    wr_st(8'h40);
    st_is(8'h40);
    wr_mem(13'h0005, rnd[7:0], 1'b1, 1'b1);
    wait_idle;
    st_is(8'h00);
    wr_st(8'h10);
    wr_st(8'h40);
    wr_mem(13'h0006, rnd[7:0], 1'b0, 1'b1);
    wait_idle;
    check(exp_wr.size(), 0);
    tally_and_finish;
  end
endmodule
